// ### rtl/multi_axis_sync_start.v
// four-axis start-condition logic with register slave
// assumes AXI4-Lite master, one write and one read in flight at most
`timescale 1ns/1ps
`include "sync_start_consts.vh"
module multi_axis_sync_start (
  core_clk,
  rstn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  axis_done,
  axis_running,
  int_n
);
  input  wire                core_clk;
  input  wire                rstn;
  input  wire [`ADDR_W-1:0]  s_axi_awaddr;
  input  wire                s_axi_awvalid;
  output wire                s_axi_awready;
  input  wire [31:0]         s_axi_wdata;
  input  wire [3:0]          s_axi_wstrb;
  input  wire                s_axi_wvalid;
  output wire                s_axi_wready;
  output reg  [1:0]          s_axi_bresp;
  output reg                 s_axi_bvalid;
  input  wire                s_axi_bready;
  input  wire [`ADDR_W-1:0]  s_axi_araddr;
  input  wire                s_axi_arvalid;
  output wire                s_axi_arready;
  output reg  [31:0]         s_axi_rdata;
  output reg  [1:0]          s_axi_rresp;
  output reg                 s_axi_rvalid;
  input  wire                s_axi_rready;
  input  wire [3:0]          axis_done;
  output wire [3:0]          axis_running;
  output wire                int_n;

  // ****************************************************************
  // write channel capture
  // ****************************************************************
  reg               aw_hold_ff;
  reg [`ADDR_W-1:0] aw_addr_ff;
  reg               w_hold_ff;
  reg [31:0]        w_data_ff;
  reg [3:0]         w_strb_ff;
  wire              wr_go;
  wire              rd_go;

  assign s_axi_awready = ~aw_hold_ff & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_ff & ~s_axi_bvalid;
  assign wr_go         = aw_hold_ff & w_hold_ff;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;

  // address and data latched separately, either order
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff  <= `ZERO32;
      w_strb_ff  <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_hold_ff <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end else if (wr_go) begin
        w_hold_ff <= 1'b0;
      end
    end
  end

  // decode of the pending write
  wire [2:0] wr_off  = aw_addr_ff[4:2];
  wire [1:0] wr_bank = aw_addr_ff[6:5];
  wire       wr_cmd  = wr_go & (aw_addr_ff == `OFF_CMD);
  wire       wr_axis = wr_go & ~aw_addr_ff[7] & (aw_addr_ff[1:0] == 2'h0);
  wire       wr_ok   = wr_cmd | (wr_axis &
                       ((wr_off == `OFF_MODE) | (wr_off == `OFF_FEED) |
                        (wr_off == `OFF_ENV2) | (wr_off == `OFF_IRQEN) |
                        (wr_off == `OFF_EVENT)));
  wire [31:0] wmask = {{8{w_strb_ff[3]}}, {8{w_strb_ff[2]}},
                       {8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};
  wire [15:0] cmd_op = w_data_ff[15:0] & `CMD_OP_MASK;
  // start command: select bits pick axes started together at fh
  wire [3:0]  cmd_sel = (wr_cmd & (cmd_op == `CMD_FH_START)) ?
                        w_data_ff[`CMD_SEL_HI:`CMD_SEL_LO] : 4'h0;

  // write response
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? `RESP_OK : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // per-axis start logic
  // ****************************************************************
  wire [3:0]   run_bc;
  wire [31:0]  rd_mode [0:3];
  wire [31:0]  rd_feed [0:3];
  wire [31:0]  rd_env  [0:3];
  wire [31:0]  rd_ien  [0:3];
  wire [3:0]   rd_st   [0:3];
  wire [15:0]  rd_cause[0:3];
  wire [3:0]   irq_ax;

  assign axis_running = run_bc;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : ax
      localparam [3:0] S_IDLE = 4'b0001;
      localparam [3:0] S_ARM  = 4'b0010;
      localparam [3:0] S_WAIT = 4'b0100;
      localparam [3:0] S_RUN  = 4'b1000;
      reg  [3:0]  state_ff;
      reg  [3:0]  nxt_state;
      reg  [31:0] mode_ff;
      reg  [31:0] feed_ff;
      reg  [31:0] env_ff;
      reg  [31:0] ien_ff;
      reg  [15:0] cause_ff;
      reg  [3:0]  seen_ff;
      reg  [3:0]  prev_run_ff;
      wire        sel_me = wr_axis & (wr_bank == g);
      wire [3:0]  mask   = mode_ff[`MASK_HI:`MASK_LO];
      wire        sw_on  = mode_ff[`SYNC_HI:`SYNC_LO] == `SYNC_STOPWAIT;
      wire        ext    = env_ff[`SMODE_BIT];
      // legacy ignores the own axis; extended keeps it
      wire [3:0]  own    = 4'h1 << g;
      wire [3:0]  eff    = ext ? mask : (mask & ~own);
      wire [3:0]  fall   = prev_run_ff & ~run_bc;
      // extended: all selected idle, operated ones seen stop
      wire        ext_ok = ((eff & run_bc) == 4'h0);
      // legacy: a fresh stop edge after arming, rest stopped
      wire        leg_ok = ((eff & run_bc) == 4'h0) &
                           (((eff & (seen_ff | fall)) != 4'h0));
      wire        cond   = ext ? ext_ok : leg_ok;
      wire        zero_f = feed_ff == `ZERO32;

      // start state machine
      always @* begin
        nxt_state = state_ff;
        case (state_ff)
          S_IDLE: begin
            if (cmd_sel[g])
              nxt_state = sw_on ? S_WAIT : (zero_f ? S_IDLE : S_RUN);
          end
          S_WAIT: begin
            if (cond)
              nxt_state = zero_f ? S_IDLE : S_RUN;
          end
          S_RUN: begin
            if (axis_done[g])
              nxt_state = S_IDLE;
          end
          default: nxt_state = S_IDLE;
        endcase
      end

      // registers, stop history, event flags
      always @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          state_ff    <= S_IDLE;
          mode_ff     <= `ZERO32;
          feed_ff     <= `ZERO32;
          env_ff      <= `ZERO32;
          ien_ff      <= `ZERO32;
          cause_ff    <= 16'h0000;
          seen_ff     <= 4'h0;
          prev_run_ff <= 4'h0;
        end else begin
          state_ff    <= nxt_state;
          prev_run_ff <= run_bc;
          if (sel_me & (wr_off == `OFF_MODE))
            mode_ff <= (mode_ff & ~wmask) | (w_data_ff & wmask);
          if (sel_me & (wr_off == `OFF_FEED))
            feed_ff <= (feed_ff & ~wmask) | (w_data_ff & wmask);
          if (sel_me & (wr_off == `OFF_ENV2))
            env_ff <= (env_ff & ~wmask) | (w_data_ff & wmask);
          if (sel_me & (wr_off == `OFF_IRQEN))
            ien_ff <= (ien_ff & ~wmask) | (w_data_ff & wmask);
          // stop edges only count once armed
          if (state_ff != S_WAIT)
            seen_ff <= 4'h0;
          else
            seen_ff <= seen_ff | fall;
          // event register writes set, cause read clears; set wins
          if (sel_me & (wr_off == `OFF_EVENT))
            cause_ff <= cause_ff | (w_data_ff[15:0] & `CAUSE_SET_MASK);
          else if (rd_go & (s_axi_araddr[7:5] == g) &
                   (s_axi_araddr[4:2] == `OFF_CAUSE))
            cause_ff <= 16'h0000;
        end
      end

      assign run_bc[g]   = (state_ff == S_RUN);
      assign rd_mode[g]  = mode_ff;
      assign rd_feed[g]  = feed_ff;
      assign rd_env[g]   = env_ff;
      assign rd_ien[g]   = ien_ff;
      assign rd_st[g]    = (state_ff == S_WAIT) ? `ST_STOPWAIT :
                           (state_ff == S_RUN) ? `ST_RUN : `ST_IDLE;
      assign rd_cause[g] = cause_ff;
      assign irq_ax[g]   = |(cause_ff[`CAUSE_HI:`CAUSE_LO] &
                             ien_ff[`CAUSE_HI:`CAUSE_LO]);
    end
  endgenerate

  assign int_n = ~(|irq_ax);

  // ****************************************************************
  // read channel
  // ****************************************************************
  wire [1:0] rd_bank = s_axi_araddr[6:5];
  wire [2:0] rd_off  = s_axi_araddr[4:2];
  reg  [31:0] rd_val;
  reg         rd_hit;

  // read mux
  always @* begin
    rd_val = `ZERO32;
    rd_hit = ~s_axi_araddr[7] & (s_axi_araddr[1:0] == 2'h0);
    case (rd_off)
      `OFF_MODE:   rd_val = rd_mode[rd_bank];
      `OFF_FEED:   rd_val = rd_feed[rd_bank];
      `OFF_ENV2:   rd_val = rd_env[rd_bank];
      `OFF_IRQEN:  rd_val = rd_ien[rd_bank];
      `OFF_STATUS: rd_val = {28'h0000000, rd_st[rd_bank]};
      `OFF_CAUSE:  rd_val = {16'h0000, rd_cause[rd_bank]};
      default:     rd_hit = 1'b0;
    endcase
    if (!rd_hit)
      rd_val = `ZERO32;
  end

  // read data register
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= `ZERO32;
      s_axi_rresp  <= `RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_val;
      s_axi_rresp  <= rd_hit ? `RESP_OK : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### rtl/sync_start_consts.vh
// constants for the four-axis stop-triggered start block
// assumes a single 125 MHz clock and an AXI4-Lite register bus
// Functional notes
// - status bits 4..7 flag accel start, accel done, decel start, decel done
// - status bits 8..12 flag comparator one to five matches
// - start-sync field bits 18..19 equal 11 defers start on stop-wait
// - stop-wait mask bits 20..23, one bit per axis X,Y,Z,U
// - start when every selected axis that operated has stopped
// - stop-mode bit: 0 legacy behaviour, 1 extended behaviour
// - legacy: start only on operating-to-stopped edge after arming
// - extended: own axis may be in mask and its stop counts
// - zero-feed positioning completes at once and counts as a stop; here it makes no stop edge, so legacy waits ignore it
// - start command selects axes; 0351h X and Y, 0551h X and Z
// - status field reads 0100 while holding in stop wait
// - event flag drives active-low interrupt when its enable bit set
`ifndef SYNC_START_CONSTS_VH
`define SYNC_START_CONSTS_VH
// ****************************************************************
// register map, eight words per axis bank of 0x20 bytes
// ****************************************************************
`define ADDR_W          8
`define BANK_SH         5
`define OFF_MODE        3'h0
`define OFF_FEED        3'h1
`define OFF_ENV2        3'h2
`define OFF_IRQEN       3'h3
`define OFF_STATUS      3'h4
`define OFF_CAUSE       3'h5
`define OFF_EVENT       3'h6
`define OFF_CMD         8'h80
// ****************************************************************
// fields
// ****************************************************************
`define SYNC_LO         18
`define SYNC_HI         19
`define SYNC_STOPWAIT   2'h3
`define MASK_LO         20
`define MASK_HI         23
`define SMODE_BIT       29
`define CAUSE_LO        4
`define CAUSE_HI        12
`define CAUSE_SET_MASK  16'h1FF0
`define CMD_SEL_LO      8
`define CMD_SEL_HI      11
`define CMD_OP_MASK     16'hF0FF
`define CMD_FH_START    16'h0051
`define ST_IDLE         4'h0
`define ST_STOPWAIT     4'h4
`define ST_RUN          4'hF
`define ZERO32          32'h00000000
`define RESP_OK         2'h0
`define RESP_SLVERR     2'h2
`endif

// ### tb/sync_start_checker_assertions.sv
// assertions on the ports of the stop-triggered start block
// assumes one clock domain with an async active-low reset
`timescale 1ns/1ps
module sync_start_checker (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic [3:0] axis_done,
  input wire logic [3:0] axis_running,
  input wire logic       int_n
);
  logic [2:0] wr_age_ff;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // cycles since the last write beat, saturating at 7
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) wr_age_ff <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wr_age_ff <= 3'h0;
    else if (wr_age_ff != 3'h7) wr_age_ff <= wr_age_ff + 3'h1;
  end
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_rd_resp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
  property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write resp stuck");
  property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data stuck");
  property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_block: assert property (p_w_block) else $error("write taken early");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken early");
  property p_run_end; (~axis_running & $past(axis_running)
    & ~($past(axis_done) | $past(axis_done, 2))) == 4'h0; endproperty
  a_run_end: assert property (p_run_end) else $error("stop w/o done");
  property p_int_cause; $fell(int_n) |-> wr_age_ff < 3'h6; endproperty
  a_int_cause: assert property (p_int_cause) else $error("stray irq");
endmodule
bind multi_axis_sync_start sync_start_checker i_sync_start_checker (
  .core_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .axis_done,
  .axis_running, .int_n);

// ### tb/motion_stub.sv
// pulse generator stand-in: ends each axis run with a done pulse
// assumes an axis holds running until it sees done
`timescale 1ns/1ps
module motion_stub (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic [3:0] slow,
  input  wire logic [3:0] axis_running,
  output logic      [3:0] axis_done
);
  logic [4:0] cnt_ff [4];
  // raise done after 4 running cycles on a quick axis, 21 on a slow one
  always @(posedge core_clk or negedge rstn) begin
    for (int i = 0; i < 4; i++) begin
      axis_done[i] <= 1'b0;
      if (!rstn || !axis_running[i] || axis_done[i])
        cnt_ff[i] <= 5'h00;
      else if (cnt_ff[i] == (slow[i] ? 5'h14 : 5'h03))
        axis_done[i] <= 1'b1;
      else
        cnt_ff[i] <= cnt_ff[i] + 5'h01;
    end
  end
endmodule

// ### tb/test_multi_axis_sync_start.sv
// self-checking bench for the stop-triggered start block
// assumes the motion stub answers each running axis
`timescale 1ns/1ps
module test_multi_axis_sync_start;
  logic        core_clk = 1'b0, rstn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF, axis_done, axis_running;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, int_n;
  int          num_errors = 0, n_compared = 0;
  always #4 core_clk = ~core_clk;
  multi_axis_sync_start i_multi_axis_sync_start (.core_clk, .rstn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .axis_done, .axis_running, .int_n);
  motion_stub i_motion_stub (.core_clk, .rstn, .slow(4'h2), .axis_running,
    .axis_done);
  // compare one word
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one bus access: write d, or read and expect d; then check response
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [1:0] r);
    logic ok;
    @(posedge core_clk);
    ok = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_bready  <= w;
    s_axi_arvalid <= !w;
    s_axi_rready  <= !w;
    for (int t = 0; t < 50 && !ok; t++) begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_bvalid || s_axi_rvalid) begin
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        ok = 1'b1;
        if (!w) chk(s_axi_rdata, d);
        chk({30'h0, w ? s_axi_bresp : s_axi_rresp}, {30'h0, r});
      end
    end
    if (!ok) chk(32'h1, 32'h0);
  endtask
  // axes seen running over 40 cycles, all stopped at the end
  task automatic watch(input logic [3:0] e);
    logic [3:0] seen;
    seen = 4'h0;
    repeat (40) @(posedge core_clk) seen = seen | axis_running;
    chk({28'h0, seen}, {28'h0, e});
    chk({28'h0, axis_running}, 32'h0);
  endtask
  // verdict and end of run
  task automatic end_of_test;
    $display("errors %0d, compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    acc(1'b0, 8'h14, 32'h0, 2'h0);
    acc(1'b0, 8'h1C, 32'h0, 2'h2);
    for (int b = 4; b <= 12; b++) begin
      acc(1'b1, 8'h0C, (b % 2) ? 32'h0 : 32'h1 << b, 2'h0);
      acc(1'b1, 8'h18, 32'h1 << b, 2'h0);
      chk({31'h0, int_n}, (b % 2) ? 32'h1 : 32'h0);
      acc(1'b0, 8'h14, 32'h1 << b, 2'h0);
      @(posedge core_clk);
      chk({31'h0, int_n}, 32'h1);
    end
    acc(1'b1, 8'h18, 32'hFFFFFFFF, 2'h0);
    acc(1'b0, 8'h14, 32'h00001FF0, 2'h0);
    $display("test event flags done");
    acc(1'b1, 8'h04, 32'h5, 2'h0);
    acc(1'b1, 8'h24, 32'h5, 2'h0);
    acc(1'b1, 8'h44, 32'h5, 2'h0);
    acc(1'b1, 8'h80, 32'h0351, 2'h0);
    watch(4'h3);
    acc(1'b1, 8'h80, 32'h0551, 2'h0);
    watch(4'h5);
    acc(1'b1, 8'h80, 32'h0352, 2'h0);
    watch(4'h0);
    $display("test start command done");
    acc(1'b1, 8'h64, 32'h0, 2'h0);
    acc(1'b1, 8'h60, 32'h003C0000, 2'h0);
    acc(1'b1, 8'h80, 32'h0851, 2'h0);
    watch(4'h0);
    acc(1'b0, 8'h70, 32'h4, 2'h0);
    acc(1'b1, 8'h80, 32'h0151, 2'h0);
    watch(4'h1);
    acc(1'b0, 8'h70, 32'h0, 2'h0);
    $display("test legacy stop wait done");
    acc(1'b1, 8'h08, 32'h20000000, 2'h0);
    acc(1'b1, 8'h00, 32'h003C0000, 2'h0);
    acc(1'b1, 8'h80, 32'h0251, 2'h0);
    acc(1'b1, 8'h80, 32'h0151, 2'h0);
    acc(1'b0, 8'h10, 32'h4, 2'h0);
    chk({28'h0, axis_running}, 32'h2);
    watch(4'h3);
    $display("test extended stop wait done");
    end_of_test;
  end
  // watchdog against a hung handshake
  initial begin
    #20000;
    num_errors++;
    end_of_test;
  end
endmodule
